// File: src/vpm_pkg.sv
package vpm_pkg;
  // ==========================================
  // timing
  localparam int CLK_KHZ  = 250_000;
  localparam int HOLD_MS  = 500;
  localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
  // ==========================================
  // value ranges and defaults
  localparam int NBAND            = 13;
  localparam logic [3:0]  BAND_LAST = 4'hc;
  localparam logic [31:0] IF_MAX   = 32'h1000_0000;
  localparam logic [31:0] FREE_HI  = 32'h01d9_05c0;
  localparam logic [31:0] MARK_RST = 32'h0000_084d;
  localparam logic [31:0] SPC_RST  = 32'h0000_00aa;
  localparam logic [3:0]  DEC_LAST = 4'h8;
  localparam logic [7:0]  SC_X4    = 8'h00;
  localparam logic [7:0]  SC_X2    = 8'h01;
  localparam logic [1:0]  CALC_DIR = 2'h0;
  localparam logic [1:0]  CALC_VPI = 2'h1;
  localparam logic [1:0]  CALC_VMI = 2'h2;
  localparam logic [1:0]  CALC_IMV = 2'h3;
  // scale code: 0 = x4, 1 = x2, n >= 2 divides by n-1
  localparam logic [12:0][7:0] SCALE_RST =
    {8'h02, 8'h06, 8'h03, {10{8'h02}}};
  localparam logic [12:0][31:0] BAND_LO = {
    32'h0000_0000, 32'h080b_efc0, 32'h02dc_6c00, 32'h018c_ba80,
    32'h0175_d720, 32'h0131_2d00, 32'h0103_6640, 32'h00c6_5d40,
    32'h0089_5440, 32'h005b_8d80, 32'h0044_aa20, 32'h0026_25a0,
    32'h0000_0000};
  localparam logic [12:0][31:0] BAND_HI = {
    32'h1af0_e900, 32'h0989_6800, 32'h0393_8700, 32'h01e8_4800,
    32'h018c_ba80, 32'h014f_b180, 32'h0121_eac0, 32'h00ec_82e0,
    32'h00a7_d8c0, 32'h007a_1200, 32'h0063_2ea0, 32'h004c_4b40,
    32'h002d_c6c0};
  localparam logic [8:0][31:0] POW10 = {
    32'h05f5_e100, 32'h0098_9680, 32'h000f_4240, 32'h0001_86a0,
    32'h0000_2710, 32'h0000_03e8, 32'h0000_0064, 32'h0000_000a,
    32'h0000_0001};
  // ==========================================
  // register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_SEL    = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_SYNTH  = 8'h0c;
  // ==========================================
  // types
  typedef enum logic [3:0] {
    E_MODE, E_VFOMODE, E_KNOBFN, E_LIMIT, E_RXIF, E_TXIF, E_BAND,
    E_RXCALC, E_RXSCALE, E_TXCALC, E_TXSCALE, E_SYNCAL, E_SPACE,
    E_TXMARK, E_RXMARK, E_CTRCAL
  } vpm_entry_t;
  typedef enum logic [1:0] {ST_RUN, ST_MENU, ST_EDIT, ST_CAL} vpm_st_t;
endpackage

// File: src/vpm_top.sv
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
// How it works
// - key output forced off while a parameter is being edited.
// - short menu tap gives memory mode; half second hold enters menu.
// - menu tap inside menu returns to normal operation.
// - menu tap during edit saves the value, then leaves menu.
// - knob scrolls entries in menu when not editing; counter cal entry shows no value.
// - counter calibration, once entered, is left only by reset.
// - knob tap starts edit and raises the edit marker.
// - second knob tap ends edit, drops marker, writes storage.
// - entry pointer starts at mode entry and survives menu exits.
// - fourteen parameters plus the operating mode entry.
// - switching to counter mode freezes the synthesizer frequency.
// - boot in vfo mode drives output; boot in counter mode none.
// - vfo mode setting subtracts or omits mark and space offsets.
// - knob press function picks decade advance or vfo a/b toggle.
// - limit on keeps band range; off allows dc to 31 MHz.
// - single receive if offset saturating at its maximum.
// - single transmit if offset, same range, all bands.
// - band entry starts at hardware band and only redirects edits.
// - per band rx/tx method of four values, default direct.
// - scale divides by 1 to 254, below 1 gives x2 then x4.
// - default scale 1 up to 10m, 2 for 6m, 5 for 2m.
// - defaults space 170, tx mark 2125, rx mark 0 Hz.
// - if offsets default zero; digit button picks the decade.
// - internal frequency by band method, then divided by scale.
// - fsk transmit uses mark, subtracts space when data is high.
module vpm_top import vpm_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // operator controls
  input  wire logic        menu_button,
  input  wire logic        knob_press,
  input  wire logic        knob_up,
  input  wire logic        knob_dn,
  input  wire logic        digit_position_button,
  input  wire logic [3:0]  band_select_inputs,
  input  wire logic        boot_counter_mode,
  // frequency path
  input  wire logic [31:0] display_freq,
  input  wire logic        tx_active,
  input  wire logic        fsk_data,
  input  wire logic        key_in,
  // outputs
  output logic             key_out,
  output logic             memory_mode_pulse,
  output logic             decade_adv_pulse,
  output logic             vfo_b_select,
  output logic             menu_active,
  output logic             edit_marker,
  output logic             nv_write,
  output logic [3:0]       nv_entry,
  output logic [3:0]       nv_band,
  output logic [31:0]      nv_data,
  output logic             synth_on,
  output logic [31:0]      synth_freq
);
  if (HOLD_CYCLES < 2) begin : g_chk
    $error("HOLD_CYCLES must be at least 2");
  end
  localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);

  typedef struct packed {
    vpm_st_t          st;
    vpm_entry_t       ent;
    logic [3:0]       sel_band;
    logic [31:0]      edit_val;
    logic [3:0]       decade;
    logic [31:0]      hold_cnt;
    logic             btn_q;
    logic             used;
    logic             op_mode;
    logic             vfo_fsk;
    logic             knob_fn;
    logic             lim_en;
    logic [28:0]      rx_if;
    logic [28:0]      tx_if;
    logic [28:0]      space_shift_offset;
    logic [28:0]      tx_mark;
    logic [28:0]      rx_mark;
    logic [15:0]      synth_calibration;
    logic [12:0][1:0] rx_calc;
    logic [12:0][1:0] tx_calc;
    logic [12:0][7:0] rx_scale;
    logic [12:0][7:0] tx_scale;
    logic [3:0]       sw_ent;
    logic [3:0]       sw_band;
    logic             boot_done;
    logic             synth_on;
    logic [31:0]      synth_freq;
    logic             key_out;
    logic             mem_mode;
    logic             decade_adv;
    logic             vfo_b;
    logic             nv_wr;
    logic [3:0]       nv_ent;
    logic [3:0]       nv_band;
    logic [31:0]      nv_data;
    logic             marker;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } vpm_s_t;

  vpm_s_t q;
  vpm_s_t n;

  // ==========================================
  // parameter store access
  function automatic logic [31:0] rd(vpm_s_t s, vpm_entry_t e,
                                     logic [3:0] b);
    logic [31:0] v;
    v = '0;
    case (e)
      E_MODE:    v[0] = s.op_mode;
      E_VFOMODE: v[0] = s.vfo_fsk;
      E_KNOBFN:  v[0] = s.knob_fn;
      E_LIMIT:   v[0] = s.lim_en;
      E_RXIF:    v[28:0] = s.rx_if;
      E_TXIF:    v[28:0] = s.tx_if;
      E_BAND:    v[3:0] = s.sel_band;
      E_RXCALC:  v[1:0] = s.rx_calc[b];
      E_RXSCALE: v[7:0] = s.rx_scale[b];
      E_TXCALC:  v[1:0] = s.tx_calc[b];
      E_TXSCALE: v[7:0] = s.tx_scale[b];
      E_SYNCAL:  v[15:0] = s.synth_calibration;
      E_SPACE:   v[28:0] = s.space_shift_offset;
      E_TXMARK:  v[28:0] = s.tx_mark;
      E_RXMARK:  v[28:0] = s.rx_mark;
      default:   v = '0;
    endcase
    return v;
  endfunction

  function automatic vpm_s_t wr(vpm_s_t s, vpm_entry_t e,
                                logic [3:0] b, logic [31:0] v);
    vpm_s_t r;
    r = s;
    case (e)
      E_MODE:    r.op_mode = v[0];
      E_VFOMODE: r.vfo_fsk = v[0];
      E_KNOBFN:  r.knob_fn = v[0];
      E_LIMIT:   r.lim_en = v[0];
      E_RXIF:    r.rx_if = v[28:0];
      E_TXIF:    r.tx_if = v[28:0];
      E_BAND:    r.sel_band = v[3:0];
      E_RXCALC:  r.rx_calc[b] = v[1:0];
      E_RXSCALE: r.rx_scale[b] = v[7:0];
      E_TXCALC:  r.tx_calc[b] = v[1:0];
      E_TXSCALE: r.tx_scale[b] = v[7:0];
      E_SYNCAL:  r.synth_calibration = v[15:0];
      E_SPACE:   r.space_shift_offset = v[28:0];
      E_TXMARK:  r.tx_mark = v[28:0];
      E_RXMARK:  r.rx_mark = v[28:0];
      default:   r = s;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] vmax(vpm_entry_t e);
    case (e)
      E_RXIF, E_TXIF, E_SPACE, E_TXMARK, E_RXMARK: return IF_MAX;
      E_BAND:               return {28'h0, BAND_LAST};
      E_RXCALC, E_TXCALC:   return 32'h3;
      E_RXSCALE, E_TXSCALE: return 32'hff;
      E_SYNCAL:             return 32'hffff;
      default:              return 32'h1;
    endcase
  endfunction

  function automatic logic [3:0] bclamp(logic [3:0] b);
    return (b > BAND_LAST) ? BAND_LAST : b;
  endfunction

  logic [3:0]  hwb;
  logic        btn_rise;
  logic        big;
  logic [31:0] delta;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [31:0] df;
  logic [1:0]  meth;
  logic [35:0] a;
  logic [35:0] b;
  logic [35:0] vs;
  logic [7:0]  sc;
  logic [35:0] outf;
  logic        setup;
  logic        acc;

  // ==========================================
  // next state
  always_comb begin
    n = q;
    n.mem_mode = 1'b0;
    n.decade_adv = 1'b0;
    n.nv_wr = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.btn_q = menu_button;
    hwb = bclamp(band_select_inputs);
    btn_rise = menu_button & ~q.btn_q;
    big = (q.ent == E_RXIF) || (q.ent == E_TXIF) ||
          (q.ent == E_SPACE) || (q.ent == E_TXMARK) ||
          (q.ent == E_RXMARK);
    delta = big ? POW10[q.decade] : 32'h1;
    unique case (q.st)
      ST_RUN: begin
        if (menu_button && !q.used) begin
          if (q.hold_cnt == HOLD_LAST) begin
            n.st = ST_MENU;
            n.used = 1'b1;
            n.hold_cnt = '0;
            n.sel_band = hwb;
          end else begin
            n.hold_cnt = q.hold_cnt + 32'h1;
          end
        end else if (!menu_button) begin
          n.mem_mode = q.btn_q & ~q.used;
          n.hold_cnt = '0;
          n.used = 1'b0;
        end
        if (knob_press) begin
          if (q.knob_fn)
            n.vfo_b = ~q.vfo_b;
          else
            n.decade_adv = 1'b1;
        end
      end
      ST_MENU: begin
        if (btn_rise) begin
          n.st = ST_RUN;
          n.used = 1'b1;
        end else if (knob_press) begin
          if (q.ent == E_CTRCAL) begin
            n.st = ST_CAL;
          end else begin
            n.st = ST_EDIT;
            n.marker = 1'b1;
            n.edit_val = rd(q, q.ent, q.sel_band);
            n.decade = '0;
          end
        end else if (knob_up && q.ent != E_CTRCAL) begin
          n.ent = vpm_entry_t'(q.ent + 4'h1);
        end else if (knob_dn && q.ent != E_MODE) begin
          n.ent = vpm_entry_t'(q.ent - 4'h1);
        end
      end
      ST_EDIT: begin
        if (btn_rise || knob_press) begin
          n = wr(n, q.ent, q.sel_band, q.edit_val);
          n.nv_wr = 1'b1;
          n.nv_ent = q.ent;
          n.nv_band = q.sel_band;
          n.nv_data = q.edit_val;
          n.marker = 1'b0;
          n.st = btn_rise ? ST_RUN : ST_MENU;
          n.used = q.used | btn_rise;
        end else if (knob_up) begin
          n.edit_val = (vmax(q.ent) - q.edit_val < delta) ?
                       vmax(q.ent) : q.edit_val + delta;
        end else if (knob_dn) begin
          // code below div1 gives x2 then x4
          n.edit_val = (q.edit_val < delta) ? '0 : q.edit_val - delta;
        end else if (digit_position_button && big) begin
          n.decade = (q.decade == DEC_LAST) ? '0 : q.decade + 4'h1;
        end
      end
      ST_CAL: n.st = ST_CAL;
    endcase

    n.key_out = key_in && (q.st != ST_EDIT);

    lo = q.lim_en ? BAND_LO[hwb] : '0;
    hi = q.lim_en ? BAND_HI[hwb] : FREE_HI;
    df = (display_freq < lo) ? lo :
         (display_freq > hi) ? hi : display_freq;
    meth = tx_active ? q.tx_calc[hwb] : q.rx_calc[hwb];
    a = {4'h0, df};
    b = {7'h0, tx_active ? q.tx_if : q.rx_if};
    unique case (meth)
      CALC_VPI: vs = a + b;
      CALC_VMI: vs = a - b;
      CALC_IMV: vs = b - a;
      CALC_DIR: vs = a;
    endcase
    // fsk offsets, space on data high
    if (q.vfo_fsk) begin
      if (tx_active)
        vs = vs - {7'h0, q.tx_mark} -
             (fsk_data ? {7'h0, q.space_shift_offset} : 36'h0);
      else
        vs = vs - {7'h0, q.rx_mark};
    end
    if (vs[35])
      vs = '0;
    sc = tx_active ? q.tx_scale[hwb] : q.rx_scale[hwb];
    if (sc == SC_X4)
      outf = vs << 2;
    else if (sc == SC_X2)
      outf = vs << 1;
    else
      outf = vs / {28'h0, sc - 8'h01};

    if (!q.boot_done) begin
      n.boot_done = 1'b1;
      n.op_mode = boot_counter_mode;
      n.synth_on = ~boot_counter_mode;
    end else if (!q.op_mode) begin
      n.synth_on = 1'b1;
      n.synth_freq = outf[31:0];
    end

    // apb slave
    setup = psel & ~penable;
    acc = psel & penable & q.pready;
    if (setup) begin
      n.pready = 1'b1;
      n.prdata = '0;
      case (paddr[7:0])
        REG_STATUS: n.prdata = {8'h0, q.nv_band, hwb, q.sel_band,
                                q.ent, 2'h0, q.st, 3'h0, q.marker};
        REG_SEL:    n.prdata = {20'h0, q.sw_band, 4'h0, q.sw_ent};
        REG_DATA:   n.prdata = rd(q, vpm_entry_t'(q.sw_ent),
                                  q.sw_band);
        REG_SYNTH:  n.prdata = q.synth_freq;
        default:    n.pslverr = 1'b1;
      endcase
      if (paddr[11:8] != 4'h0) begin
        n.pslverr = 1'b1;
        n.prdata = '0;
      end
    end
    if (acc && pwrite && !q.pslverr) begin
      if (paddr[7:0] == REG_SEL) begin
        n.sw_ent = pwdata[3:0];
        n.sw_band = bclamp(pwdata[11:8]);
      end else if (paddr[7:0] == REG_DATA) begin
        n = wr(n, vpm_entry_t'(q.sw_ent), q.sw_band, pwdata);
      end
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= '0;
      q.st <= ST_RUN;
      q.ent <= E_MODE;
      q.rx_calc <= {NBAND{CALC_DIR}};
      q.tx_calc <= {NBAND{CALC_DIR}};
      q.rx_scale <= SCALE_RST;
      q.tx_scale <= SCALE_RST;
      q.tx_mark <= MARK_RST[28:0];
      q.space_shift_offset <= SPC_RST[28:0];
    end else begin
      q <= n;
    end
  end

  assign pready            = q.pready;
  assign prdata            = q.prdata;
  assign pslverr           = q.pslverr;
  assign key_out           = q.key_out;
  assign memory_mode_pulse = q.mem_mode;
  assign decade_adv_pulse  = q.decade_adv;
  assign vfo_b_select      = q.vfo_b;
  assign menu_active       = (q.st != ST_RUN);
  assign edit_marker       = q.marker;
  assign nv_write          = q.nv_wr;
  assign nv_entry          = q.nv_ent;
  assign nv_band           = q.nv_band;
  assign nv_data           = q.nv_data;
  assign synth_on          = q.synth_on;
  assign synth_freq        = q.synth_freq;

  // ==========================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_key_blocked: assert property (
    q.st == ST_EDIT |=> !key_out) else $error("key passed in edit");
  a_hold_enter: assert property (
    q.st == ST_RUN && menu_button && !q.used && q.hold_cnt == HOLD_LAST
    |=> q.st == ST_MENU && q.sel_band == $past(hwb))
    else $error("hold did not enter menu");
  a_tap_exit: assert property (
    q.st == ST_MENU && btn_rise |=> q.st == ST_RUN && !menu_active)
    else $error("menu tap did not exit");
  a_short_save: assert property (
    q.st == ST_EDIT && btn_rise |=> nv_write && q.st == ST_RUN
    && nv_data == $past(q.edit_val)) else $error("shortcut save lost");
  a_cal_trap: assert property (
    q.st == ST_CAL |=> q.st == ST_CAL [*3]) else $error("cal exited");
  a_marker_on: assert property (
    q.st == ST_MENU && !btn_rise && knob_press && q.ent != E_CTRCAL
    |=> edit_marker && q.st == ST_EDIT) else $error("no marker");
  a_tap_store: assert property (
    q.st == ST_EDIT && !btn_rise && knob_press
    |=> nv_write && !edit_marker ##1 !nv_write)
    else $error("tap did not store");
  a_ptr_kept: assert property (
    q.st == ST_MENU && btn_rise |=> q.ent == $past(q.ent))
    else $error("pointer moved on exit");
  a_ctr_freeze: assert property (
    q.boot_done && q.op_mode |=> $stable(synth_freq))
    else $error("synth moved in counter mode");
  a_step_clamp: assert property (
    q.st == ST_EDIT |=> q.edit_val <= vmax(q.ent))
    else $error("edit value beyond limit");
  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing");

  c_menu_hold: cover property (q.st == ST_RUN ##1 q.st == ST_MENU);
  c_edit_save: cover property (q.st == ST_EDIT ##1 nv_write);
  c_cal_enter: cover property (q.st == ST_MENU ##1 q.st == ST_CAL);
  c_mem_tap:   cover property (memory_mode_pulse);
endmodule

// File: verif/vpm_op_model.sv
`timescale 1ns/100ps
// ==========================================
// operator controls: menu button and knob
module vpm_op_model (
  // clock
  input  wire logic mclk,
  // operator controls
  output logic      menu_button,
  output logic      knob_press,
  output logic      knob_up,
  output logic      knob_dn,
  output logic      digit_position_button
);
  initial begin
    menu_button           = 1'b0;
    knob_press            = 1'b0;
    knob_up               = 1'b0;
    knob_dn               = 1'b0;
    digit_position_button = 1'b0;
  end

  // press for n edges, then release
  task automatic hold_menu(input int n);
    @(posedge mclk) menu_button <= 1'b1;
    repeat (n) @(posedge mclk);
    menu_button <= 1'b0;
  endtask

  task automatic tap_knob();
    @(posedge mclk) knob_press <= 1'b1;
    @(posedge mclk) knob_press <= 1'b0;
  endtask

  // one-cycle digit position button pulse
  task automatic tap_digit();
    @(posedge mclk) digit_position_button <= 1'b1;
    @(posedge mclk) digit_position_button <= 1'b0;
  endtask

  // one-cycle detent pulses with a gap
  task automatic turn(input bit up, input int n);
    repeat (n) begin
      @(posedge mclk);
      knob_up <= up;
      knob_dn <= !up;
      @(posedge mclk);
      knob_up <= 1'b0;
      knob_dn <= 1'b0;
    end
  endtask
endmodule

// File: verif/vpm_top_tb_top.sv
`timescale 1ns/100ps
module vpm_top_tb_top;
  import vpm_pkg::*;
  logic mclk, rstn, psel, penable, pwrite, tx_active, fsk_data, key_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, display_freq, rd;
  logic [3:0]  band_sel;
  logic mb, kp, ku, kd, dp, pready, pslverr, key_out, mem_p, dec_p;
  logic vfo_b, menu_active, edit_marker, nv_write, synth_on, last_err;
  logic [31:0] prdata, nv_data, synth_freq;
  logic [3:0]  nv_entry, nv_band;
  int error_cnt, num_checks, nv_cnt, mem_cnt;

  vpm_op_model u_op (.mclk(mclk), .menu_button(mb), .knob_press(kp),
    .knob_up(ku), .knob_dn(kd), .digit_position_button(dp));
  vpm_top #(.HOLD_CYCLES(8)) u_dut (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .menu_button(mb), .knob_press(kp), .knob_up(ku), .knob_dn(kd),
    .digit_position_button(dp), .band_select_inputs(band_sel),
    .boot_counter_mode(1'b0), .display_freq(display_freq),
    .tx_active(tx_active), .fsk_data(fsk_data), .key_in(key_in),
    .key_out(key_out), .memory_mode_pulse(mem_p),
    .decade_adv_pulse(dec_p), .vfo_b_select(vfo_b),
    .menu_active(menu_active), .edit_marker(edit_marker),
    .nv_write(nv_write), .nv_entry(nv_entry), .nv_band(nv_band),
    .nv_data(nv_data), .synth_on(synth_on), .synth_freq(synth_freq));

  // ==========================================
  // clock, monitors, watchdog
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (nv_write === 1'b1) nv_cnt++;
    if (mem_p === 1'b1) mem_cnt++;
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  // ==========================================
  // shared tasks
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input bit wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk) penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    last_err = pslverr;
    if (n >= 50) chk(1'b0, 1'b1, "apb hang");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_val(input logic [3:0] band, entry, input logic [31:0] v);
    apb(1'b1, {4'h0, REG_SEL}, {20'h0, band, 4'h0, entry}, rd);
    apb(1'b1, {4'h0, REG_DATA}, v, rd);
  endtask

  task automatic get_val(input logic [3:0] band, entry, output logic [31:0] v);
    apb(1'b1, {4'h0, REG_SEL}, {20'h0, band, 4'h0, entry}, rd);
    apb(1'b0, {4'h0, REG_DATA}, 32'h0, v);
  endtask

  // ==========================================
  // scenarios
  task automatic t_defaults();
    logic [3:0]  ent [7] = '{4'hc, 4'hd, 4'he, 4'h4, 4'h5, 4'ha, 4'h8};
    logic [3:0]  bnd [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hb, 4'ha};
    logic [31:0] exv [7] = '{SPC_RST, MARK_RST, 32'h0, 32'h0, 32'h0,
                             32'h6, 32'h3};
    apb(1'b0, {4'h0, REG_SEL}, 32'h0, rd);
    chk(rd[3:0], 4'h0, "pointer at boot");
    chk(synth_on, 1'b1, "synth on at vfo boot");
    for (int i = 0; i < 7; i++) begin
      get_val(bnd[i], ent[i], rd);
      chk(rd, exv[i], "default value");
    end
    get_val(4'h5, 4'h9, rd);
    chk(rd, {30'h0, CALC_DIR}, "default tx calc");
    $display("test defaults done");
  endtask

  task automatic t_menu_edit();
    u_op.hold_menu(2);
    idle(4);
    chk(mem_cnt, 1, "short tap memory pulse");
    chk(menu_active, 1'b0, "short tap stays run");
    u_op.hold_menu(10);
    idle(2);
    chk(menu_active, 1'b1, "hold enters menu");
    u_op.turn(1'b1, 3);
    apb(1'b0, {4'h0, REG_STATUS}, 32'h0, rd);
    chk(rd[11:8], 4'h3, "scroll to limit");
    u_op.tap_knob();
    idle(2);
    chk(edit_marker, 1'b1, "marker on");
    key_in <= 1'b1;
    idle(3);
    chk(key_out, 1'b0, "key gated in edit");
    u_op.turn(1'b1, 1);
    u_op.tap_knob();
    idle(2);
    chk(nv_cnt, 1, "store on tap");
    chk({nv_entry, nv_data}, {4'h3, 32'h1}, "stored value");
    chk(edit_marker, 1'b0, "marker off");
    chk(key_out, 1'b1, "key passes after edit");
    u_op.tap_knob();
    u_op.turn(1'b0, 1);
    u_op.hold_menu(2);
    idle(3);
    chk(nv_cnt, 2, "shortcut store");
    chk(nv_data, 32'h0, "shortcut value");
    chk(menu_active, 1'b0, "shortcut leaves menu");
    u_op.hold_menu(10);
    idle(2);
    apb(1'b0, {4'h0, REG_STATUS}, 32'h0, rd);
    chk(rd[11:8], 4'h3, "pointer kept");
    u_op.hold_menu(2);
    idle(2);
    chk(menu_active, 1'b0, "tap leaves menu");
    u_op.hold_menu(10);
    idle(2);
    u_op.turn(1'b1, 1);
    u_op.tap_knob();
    u_op.tap_digit();
    u_op.turn(1'b1, 1);
    u_op.tap_knob();
    idle(2);
    chk({nv_entry, nv_data}, {4'h4, 32'd10}, "decade step");
    u_op.hold_menu(2);
    idle(2);
    key_in <= 1'b0;
    $display("test menu_edit done");
  endtask

  task automatic t_calc();
    logic [1:0]  cm [3] = '{CALC_VPI, CALC_VMI, CALC_IMV};
    logic [31:0] df [3] = '{32'd5000, 32'd5000, 32'd300};
    logic [31:0] ex [3] = '{32'd6000, 32'd4000, 32'd700};
    apb(1'b1, 12'h010, 32'h0, rd);
    chk(last_err, 1'b1, "unmapped error");
    band_sel <= 4'hf;
    idle(2);
    apb(1'b0, {4'h0, REG_STATUS}, 32'h0, rd);
    chk(rd[19:16], 4'hc, "band input clamp");
    band_sel <= 4'h0;
    set_val(4'h0, 4'h4, 32'd1000);
    for (int i = 0; i < 3; i++) begin
      set_val(4'h0, 4'h7, {30'h0, cm[i]});
      display_freq <= df[i];
      idle(3);
      chk(synth_freq, ex[i], "band method");
    end
    set_val(4'h0, 4'h7, {30'h0, CALC_VMI});
    set_val(4'h0, 4'h8, {24'h0, SC_X2});
    display_freq <= 32'd5000;
    idle(3);
    chk(synth_freq, 32'd8000, "times two scale");
    set_val(4'h0, 4'h8, 32'h2);
    set_val(4'h0, 4'h7, {30'h0, CALC_DIR});
    $display("test calc done");
  endtask

  task automatic t_fsk_mode();
    logic [31:0] last;
    set_val(4'h0, 4'h1, 32'h1);
    tx_active    <= 1'b1;
    display_freq <= 32'd10000;
    idle(3);
    chk(synth_freq, 32'd7875, "mark freq");
    fsk_data <= 1'b1;
    idle(3);
    chk(synth_freq, 32'd7705, "space freq");
    fsk_data  <= 1'b0;
    tx_active <= 1'b0;
    set_val(4'h0, 4'h1, 32'h0);
    idle(3);
    last = synth_freq;
    set_val(4'h0, 4'h0, 32'h1);
    display_freq <= 32'd20000;
    idle(4);
    chk(synth_freq, last, "counter keeps freq");
    $display("test fsk_mode done");
  endtask

  // ==========================================
  // verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    band_sel = 4'h0;
    display_freq = 32'h0;
    tx_active = 1'b0;
    fsk_data = 1'b0;
    key_in = 1'b0;
    idle(5);
    rstn <= 1'b1;
    idle(2);
    t_defaults();
    t_menu_edit();
    t_calc();
    t_fsk_mode();
    complete_run();
  end
endmodule
